// ### dsim_pkg.sv
// package for the drive status interlock monitor controller
package dsim_pkg;
   // register byte offsets
   localparam logic [11:0] OFF_CTRL = 12'h000;
   localparam logic [11:0] OFF_CFG = 12'h004;
   localparam logic [11:0] OFF_WIN = 12'h008;
   localparam logic [11:0] OFF_SPDTOL = 12'h00C;
   localparam logic [11:0] OFF_STAT = 12'h010;
   localparam logic [11:0] OFF_IRQ = 12'h014;
   localparam logic [11:0] OFF_MASK = 12'h018;
   localparam logic [11:0] OFF_LIVE = 12'h01C;
   localparam logic [11:0] OFF_SPDCMD = 12'h020;
   // control bits
   localparam int CTRL_FWD = 0;
   localparam int CTRL_REV = 1;
   localparam int CTRL_ENABLE = 2;
   // config bits: polarity of each status input, 1 = inverted code; bits 4 and 5 enable the backup speed and phase current checks
   localparam int CFG_FAULT_INV = 0;
   localparam int CFG_READY_INV = 1;
   localparam int CFG_RUN_INV = 2;
   localparam int CFG_CUR_INV = 3;
   localparam int CFG_USE_SPEED = 4;
   localparam int CFG_USE_CUR = 5;
   // event bits in status, irq and mask registers
   localparam int EV_FAULT = 0;
   localparam int EV_NOREADY = 1;
   localparam int EV_RUN = 2;
   localparam int EV_CUR = 3;
   localparam int EV_BK_MOTION = 4;
   localparam int EV_BK_SPEED = 5;
   localparam int EV_PHASE = 6;
   localparam int EV_W = 7;
   // function select codes for the drive's status terminals
   localparam logic [7:0] FSEL_FAULT_POS = 8'h63;
   localparam logic [7:0] FSEL_FAULT_NEG = 8'hC7;
   localparam logic [7:0] FSEL_READY_POS = 8'h0B;
   localparam logic [7:0] FSEL_READY_NEG = 8'h6F;
   localparam logic [7:0] FSEL_RUN_POS = 8'h00;
   localparam logic [7:0] FSEL_RUN_NEG = 8'h64;
   localparam logic [7:0] FSEL_CUR_POS = 8'h0C;
   localparam logic [7:0] FSEL_CUR_NEG = 8'h70;
   localparam int CUR_LEVEL_DEFAULT_PCT = 150;
   localparam int CUR_LEVEL_INTERLOCK_PCT = 20;
   // reset values
   localparam logic [31:0] RST_WIN = 32'h0000_1000;
   localparam logic [31:0] RST_READY_WIN = 32'h0000_1000;
   localparam logic [15:0] RST_SPDTOL = 16'h0010;
   localparam logic [5:0] RST_CFG = 6'h00;
   typedef struct packed {
      logic fault;
      logic ready;
      logic running;
      logic curDet;
   } dsim_drv_s;
   typedef struct packed {
      logic motion;
      logic [2:0] phaseCur;
      logic [15:0] speed;
   } dsim_bk_s;
endpackage : dsim_pkg

// ### dsim_ctrl.sv
// interlock controller watching a motor drive's status outputs and backup sensors
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module dsim_ctrl
   import dsim_pkg::*;
#(
   parameter int WIN_W = 32
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire dsim_pkg::dsim_drv_s drvIn,
   input wire dsim_pkg::dsim_bk_s bkIn,
   output logic fwdStart,
   output logic revStart,
   output logic [15:0] speedCmd,
   output logic irq
);
   import dsim_pkg::*;

   // ==========================================================
   // registers
   logic [2:0] ctrl_ff;
   logic [5:0] cfg_ff;
   logic [WIN_W-1:0] win_ff;
   logic [15:0] spdTol_ff;
   logic [15:0] spdCmd_ff;
   logic [EV_W-1:0] stat_ff;
   logic [EV_W-1:0] mask_ff;
   logic [EV_W-1:0] nxt_stat;
   logic [EV_W-1:0] evt;
   logic [WIN_W-1:0] decel_ff;
   logic [WIN_W-1:0] rdyCnt_ff;
   logic [WIN_W-1:0] runMis_ff;
   logic [WIN_W-1:0] curMis_ff;
   logic [WIN_W-1:0] motMis_ff;
   logic [WIN_W-1:0] spdMis_ff;
   logic startCmd;
   logic inDecel;
   logic faultAct;
   logic readyAct;
   logic runAct;
   logic curAct;
   logic spdGap;
   logic phaseBad;
   logic wrEn;
   logic rdEn;
   logic addrOk;
   logic [15:0] spdDiff;

   assign pready = 1'b1;
   assign wrEn = psel && penable && pwrite;
   assign rdEn = psel && penable && !pwrite;
   always_comb begin
      unique case (paddr)
         OFF_CTRL, OFF_CFG, OFF_WIN, OFF_SPDTOL, OFF_STAT, OFF_IRQ, OFF_MASK, OFF_LIVE,
         OFF_SPDCMD: addrOk = 1'b1;
         default: addrOk = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !addrOk;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_ff <= 3'h0;
         cfg_ff <= RST_CFG;
         win_ff <= WIN_W'(RST_WIN);
         spdTol_ff <= RST_SPDTOL;
         spdCmd_ff <= 16'h0000;
         mask_ff <= '0;
      end else if (wrEn) begin
         unique case (paddr)
            OFF_CTRL: ctrl_ff <= pwdata[2:0];
            OFF_CFG: cfg_ff <= pwdata[5:0];
            OFF_WIN: win_ff <= pwdata[WIN_W-1:0];
            OFF_SPDTOL: spdTol_ff <= pwdata[15:0];
            OFF_MASK: mask_ff <= pwdata[EV_W-1:0];
            OFF_SPDCMD: spdCmd_ff <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            OFF_CTRL: prdata <= {29'h0, ctrl_ff};
            OFF_CFG: prdata <= {26'h0, cfg_ff};
            OFF_WIN: prdata <= 32'(win_ff);
            OFF_SPDTOL: prdata <= {16'h0, spdTol_ff};
            OFF_STAT: prdata <= {25'h0, stat_ff};
            OFF_IRQ: prdata <= {25'h0, stat_ff & mask_ff};
            OFF_MASK: prdata <= {25'h0, mask_ff};
            OFF_LIVE: prdata <= {24'h0, inDecel, startCmd, 2'h0, drvIn};
            OFF_SPDCMD: prdata <= {16'h0, spdCmd_ff};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // drive commands; forward and reverse never both driven
   assign startCmd = ctrl_ff[CTRL_ENABLE] && (ctrl_ff[CTRL_FWD] ^ ctrl_ff[CTRL_REV]);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fwdStart <= 1'b0;
         revStart <= 1'b0;
         speedCmd <= 16'h0000;
      end else begin
         fwdStart <= startCmd && ctrl_ff[CTRL_FWD];
         revStart <= startCmd && ctrl_ff[CTRL_REV];
         speedCmd <= startCmd ? spdCmd_ff : 16'h0000;
      end
   end

   // ==========================================================
   // status decode by selected polarity
   // inverted fault: a low line is a fault or a broken wire, both alarm
   assign faultAct = cfg_ff[CFG_FAULT_INV] ? !drvIn.fault : drvIn.fault;
   assign readyAct = drvIn.ready ^ cfg_ff[CFG_READY_INV];
   assign runAct = drvIn.running ^ cfg_ff[CFG_RUN_INV];
   assign curAct = drvIn.curDet ^ cfg_ff[CFG_CUR_INV];

   // deceleration allowance counts down after start drops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         decel_ff <= '0;
      end else if (fwdStart || revStart) begin
         decel_ff <= win_ff;
      end else if (decel_ff != '0) begin
         decel_ff <= decel_ff - WIN_W'(1);
      end
   end
   assign inDecel = !(fwdStart || revStart) && (decel_ff != '0);

   // ready must appear within the window after reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdyCnt_ff <= WIN_W'(RST_READY_WIN);
      end else if (readyAct) begin
         rdyCnt_ff <= win_ff;
      end else if (rdyCnt_ff != '0) begin
         rdyCnt_ff <= rdyCnt_ff - WIN_W'(1);
      end
   end

   // mismatch counters: start on with status off, or status lingering past decel; the speed counter runs on a speed gap or phase loss
   function automatic logic [WIN_W-1:0] misCount(input logic [WIN_W-1:0] cur,
                                                input logic bad);
      misCount = bad ? ((cur == '1) ? cur : cur + WIN_W'(1)) : '0;
   endfunction : misCount

   assign spdDiff = (bkIn.speed > speedCmd) ? (bkIn.speed - speedCmd) : (speedCmd - bkIn.speed);
   assign spdGap = cfg_ff[CFG_USE_SPEED] && (fwdStart || revStart) && (spdDiff > spdTol_ff);
   assign phaseBad = cfg_ff[CFG_USE_CUR] && (fwdStart || revStart)
                     && (bkIn.phaseCur != 3'b111);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         runMis_ff <= '0;
         curMis_ff <= '0;
         motMis_ff <= '0;
         spdMis_ff <= '0;
      end else begin
         runMis_ff <= misCount(runMis_ff, (fwdStart || revStart) ? !runAct
                                         : (runAct && !inDecel));
         curMis_ff <= misCount(curMis_ff, (fwdStart || revStart) ? !curAct
                                         : (curAct && !inDecel));
         motMis_ff <= misCount(motMis_ff, (fwdStart || revStart) ? !bkIn.motion
                                         : (bkIn.motion && !inDecel));
         spdMis_ff <= misCount(spdMis_ff, spdGap || phaseBad);
      end
   end

   // ==========================================================
   // sticky events, write one to clear; a new event wins over the clear
   always_comb begin
      evt = '0;
      evt[EV_FAULT] = faultAct;
      evt[EV_NOREADY] = (rdyCnt_ff == '0) && !readyAct;
      evt[EV_RUN] = runMis_ff >= win_ff;
      evt[EV_CUR] = curMis_ff >= win_ff;
      evt[EV_BK_MOTION] = motMis_ff >= win_ff;
      evt[EV_BK_SPEED] = spdGap && (spdMis_ff >= win_ff);
      evt[EV_PHASE] = phaseBad && (spdMis_ff >= win_ff);
      nxt_stat = stat_ff;
      if (wrEn && paddr == OFF_STAT) begin
         nxt_stat = stat_ff & ~pwdata[EV_W-1:0];
      end
      nxt_stat = nxt_stat | evt;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stat_ff <= '0;
      end else begin
         stat_ff <= nxt_stat;
      end
   end

   assign irq = |(stat_ff & mask_ff);

   // ==========================================================
   // checks
   sequence S_START_HELD;
      (fwdStart || revStart) && !runAct;
   endsequence
   AST_FAULT_SETS: assert property (@(posedge clk) disable iff (!rst_b)
      faultAct |=> stat_ff[EV_FAULT]) else $error("fault not latched");
   AST_INV_FAULT: assert property (@(posedge clk) disable iff (!rst_b)
      (cfg_ff[CFG_FAULT_INV] && !drvIn.fault) |=> stat_ff[EV_FAULT])
      else $error("inverted fault low not flagged");
   AST_NO_BOTH: assert property (@(posedge clk) disable iff (!rst_b)
      !(fwdStart && revStart)) else $error("both start commands driven");
   AST_RUN_ALARM: assert property (@(posedge clk) disable iff (!rst_b)
      (S_START_HELD and (runMis_ff >= win_ff)) |=> stat_ff[EV_RUN])
      else $error("run mismatch not flagged");
   AST_DECEL_QUIET: assert property (@(posedge clk) disable iff (!rst_b)
      (inDecel && curAct) |=> (curMis_ff == '0))
      else $error("current counted during deceleration");
   AST_DECEL_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
      $fell(fwdStart || revStart) |-> (decel_ff == $past(win_ff)))
      else $error("deceleration allowance not loaded");
   AST_READY_ALARM: assert property (@(posedge clk) disable iff (!rst_b)
      (rdyCnt_ff == '0 && !readyAct) |=> stat_ff[EV_NOREADY])
      else $error("missing ready not flagged");
   AST_IRQ: assert property (@(posedge clk) disable iff (!rst_b)
      (stat_ff[EV_BK_MOTION] && mask_ff[EV_BK_MOTION]) |-> irq)
      else $error("backup alarm not on interrupt");
   AST_PHASE: assert property (@(posedge clk) disable iff (!rst_b)
      (phaseBad && spdMis_ff >= win_ff) |=> stat_ff[EV_PHASE])
      else $error("phase loss not flagged");

   // ==========================================================
   // command path checks
   sequence S_STARTED;
      fwdStart || revStart;
   endsequence
   sequence S_START_DROP;
      (fwdStart || revStart) ##1 !(fwdStart || revStart);
   endsequence
   AST_SPD_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
      !(fwdStart || revStart) |-> (speedCmd == 16'h0000))
      else $error("speed command left on while stopped");
   AST_FWD_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_b)
      (startCmd && ctrl_ff[CTRL_FWD]) |=> fwdStart)
      else $error("forward start not driven");
   AST_REV_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_b)
      (startCmd && ctrl_ff[CTRL_REV]) |=> revStart)
      else $error("reverse start not driven");
   AST_STOP_DROPS: assert property (@(posedge clk) disable iff (!rst_b)
      !startCmd |=> !(fwdStart || revStart))
      else $error("start held after stop");
   AST_SPD_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_b)
      startCmd |=> (speedCmd == $past(spdCmd_ff)))
      else $error("speed command not forwarded");

   // ==========================================================
   // deceleration allowance checks
   // the window must open on the cycle the start drops, else a slow drive alarms at once
   AST_DECEL_OPEN: assert property (@(posedge clk) disable iff (!rst_b)
      S_START_DROP |-> ((decel_ff == '0) || inDecel))
      else $error("deceleration window not open");
   AST_DECEL_COUNT: assert property (@(posedge clk) disable iff (!rst_b)
      (!(fwdStart || revStart) && decel_ff != '0) |=> (decel_ff == $past(decel_ff) - WIN_W'(1)))
      else $error("deceleration allowance not counting");
   AST_RUN_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
      (S_STARTED and runAct) |=> (runMis_ff == '0))
      else $error("run counter not cleared while running");
   AST_CUR_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
      (S_STARTED and curAct) |=> (curMis_ff == '0))
      else $error("current counter not cleared while running");
   AST_RUN_LINGER: assert property (@(posedge clk) disable iff (!rst_b)
      (!(fwdStart || revStart) && !inDecel && runAct && runMis_ff != '1)
      |=> (runMis_ff == $past(runMis_ff) + WIN_W'(1)))
      else $error("lingering run not counted");
   AST_MOTION_LINGER: assert property (@(posedge clk) disable iff (!rst_b)
      (!(fwdStart || revStart) && !inDecel && bkIn.motion && motMis_ff != '1)
      |=> (motMis_ff == $past(motMis_ff) + WIN_W'(1)))
      else $error("lingering motion not counted");
   AST_SPD_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
      !(spdGap || phaseBad) |=> (spdMis_ff == '0))
      else $error("speed counter not cleared");

   // ==========================================================
   // alarm checks
   sequence S_CUR_MISSING;
      (fwdStart || revStart) && !curAct;
   endsequence
   AST_CUR_ALARM: assert property (@(posedge clk) disable iff (!rst_b)
      (S_CUR_MISSING and (curMis_ff >= win_ff)) |=> stat_ff[EV_CUR])
      else $error("current mismatch not flagged");
   AST_MOTION_ALARM: assert property (@(posedge clk) disable iff (!rst_b)
      (motMis_ff >= win_ff) |=> stat_ff[EV_BK_MOTION])
      else $error("motion mismatch not flagged");
   AST_SPEED_ALARM: assert property (@(posedge clk) disable iff (!rst_b)
      (spdGap && spdMis_ff >= win_ff) |=> stat_ff[EV_BK_SPEED])
      else $error("speed gap not flagged");
   AST_READY_COUNT: assert property (@(posedge clk) disable iff (!rst_b)
      (!readyAct && rdyCnt_ff != '0) |=> (rdyCnt_ff == $past(rdyCnt_ff) - WIN_W'(1)))
      else $error("ready watchdog not counting");
   // an alarm must survive until software clears it, or it can be missed between polls
   AST_FAULT_STICKY: assert property (@(posedge clk) disable iff (!rst_b)
      (stat_ff[EV_FAULT] && !(wrEn && paddr == OFF_STAT && pwdata[EV_FAULT]))
      |=> stat_ff[EV_FAULT])
      else $error("fault alarm lost");
   AST_NOREADY_STICKY: assert property (@(posedge clk) disable iff (!rst_b)
      (stat_ff[EV_NOREADY] && !(wrEn && paddr == OFF_STAT && pwdata[EV_NOREADY]))
      |=> stat_ff[EV_NOREADY])
      else $error("ready alarm lost");
   AST_RUN_CLEARED: assert property (@(posedge clk) disable iff (!rst_b)
      (wrEn && paddr == OFF_STAT && pwdata[EV_RUN] && !evt[EV_RUN]) |=> !stat_ff[EV_RUN])
      else $error("run alarm not cleared");
   AST_STAT_READ: assert property (@(posedge clk) disable iff (!rst_b)
      (psel && !penable && !pwrite && paddr == OFF_STAT)
      |=> (prdata == {25'h0, $past(stat_ff)}))
      else $error("status read data wrong");
endmodule : dsim_ctrl
`default_nettype wire

// ### dsim_drv_model.sv
// behavioural motor drive: status outputs and backup detectors
`timescale 1ns/1ns
`default_nettype none
module dsim_drv_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic start,
   input wire logic [15:0] speedCmd,
   input wire logic [7:0] decel,
   input wire logic [3:0] inv,
   input wire logic trip,
   input wire logic [2:0] phOk,
   input wire logic [15:0] spdErr,
   output dsim_pkg::dsim_drv_s drv,
   output dsim_pkg::dsim_bk_s bk
);
   import dsim_pkg::*;
   // ======================================
   // run state
   logic [7:0] decelCnt_ff;
   logic ready_ff;
   wire logic moving = start | (decelCnt_ff != 8'h00);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         decelCnt_ff <= 8'h00;
         ready_ff <= 1'b0;
      end else begin
         ready_ff <= 1'b1;
         // output keeps going until the ramp down is over
         decelCnt_ff <= start ? decel : decelCnt_ff - {7'h00, decelCnt_ff != 8'h00};
      end
   end
   // ======================================
   // pins; inv[i] set means a negative logic code was chosen
   // load current stays above the lowered detection level while turning
   assign drv = '{fault: trip ^ inv[0],
                  ready: ready_ff ^ inv[1],
                  running: moving ^ inv[2],
                  curDet: moving ^ inv[3]};
   assign bk = '{motion: moving,
                 phaseCur: moving ? phOk : 3'b000,
                 speed: start ? 16'(speedCmd + spdErr) : 16'h0000};
endmodule : dsim_drv_model
`default_nettype wire

// ### tb_drive_status_interlock_monitor.sv
// self-checking testbench for the interlock monitor
`timescale 1ns/1ns
`default_nettype none
module tb_drive_status_interlock_monitor;
   import dsim_pkg::*;
   logic clk, rst_b, psel, penable, pwrite, pready, pslverr, irq, trip, errSeen;
   logic fwdStart, revStart;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdVal, rng;
   logic [15:0] speedCmd, spdErr;
   logic [7:0] decel;
   logic [3:0] inv;
   logic [2:0] phOk;
   dsim_drv_s drvIn;
   dsim_bk_s bkIn;
   int errorCnt;
   int checksDone;
   dsim_ctrl #(.WIN_W(32)) dsim_ctrl_i (.clk(clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .drvIn(drvIn), .bkIn(bkIn), .fwdStart(fwdStart),
      .revStart(revStart), .speedCmd(speedCmd), .irq(irq));
   dsim_drv_model dsim_drv_model_i (.clk(clk), .rst_b(rst_b), .start(fwdStart | revStart),
      .speedCmd(speedCmd), .decel(decel), .inv(inv), .trip(trip), .phOk(phOk),
      .spdErr(spdErr), .drv(drvIn), .bk(bkIn));
   // ======================================
   // helpers
   task automatic completeRun;
      $display("errors %0d checks %0d", errorCnt, checksDone);
      if (errorCnt == 0 && checksDone > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : completeRun
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         errorCnt++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         errorCnt++;
         completeRun();
      end
      rdVal = prdata;
      errSeen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdVal, e);
   endtask : rd
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : wt
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   // ======================================
   // clock, watchdog, sequence
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      repeat (100000) @(posedge clk);
      errorCnt++;
      completeRun();
   end
   initial begin
      int ct[4] = '{5, 6, 7, 4};
      int es[5] = '{0, 32'h1C, 32'h40, 32'h20, 0};
      {rst_b, psel, penable, pwrite, trip, paddr, pwdata} = '0;
      {decel, inv, spdErr} = '0;
      phOk = 3'b111;
      rng = 32'h427A;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      rd(OFF_WIN, RST_WIN);
      rd(OFF_SPDTOL, {16'h0000, RST_SPDTOL});
      rd(OFF_STAT, 32'h0);
      rd(12'h040, 32'h0);
      chk({31'h0, errSeen}, 32'h1);
      apb(1'b1, OFF_WIN, 32'h10);
      apb(1'b1, OFF_MASK, 32'h7F);
      rd(OFF_MASK, 32'h7F);
      rng = xs(rng);
      apb(1'b1, OFF_SPDCMD, rng & 32'h0FFF);
      apb(1'b1, OFF_CFG, 32'h30);
      decel <= 8'd8;
      foreach (ct[i]) begin
         apb(1'b1, OFF_CTRL, ct[i]);
         wt(40);
         chk({fwdStart, revStart}, {ct[i] == 5, ct[i] == 6});
         chk(speedCmd, (ct[i] == 5 || ct[i] == 6) ? rng[15:0] & 16'h0FFF : 16'h0000);
         rd(OFF_LIVE, (ct[i] == 5 || ct[i] == 6) ? 32'h47 : 32'h04);
      end
      rd(OFF_STAT, 32'h0);
      foreach (es[k]) begin
         decel <= (k == 1) ? 8'd40 : 8'd8;
         phOk <= (k == 2) ? 3'b101 : 3'b111;
         spdErr <= (k == 3) ? 16'h0020 : 16'h0000;
         inv <= (k == 4) ? {FSEL_CUR_NEG > 99, FSEL_RUN_NEG > 99, FSEL_READY_NEG > 99,
            FSEL_FAULT_NEG > 99} : {FSEL_CUR_POS > 99, FSEL_RUN_POS > 99,
            FSEL_READY_POS > 99, FSEL_FAULT_POS > 99};
         apb(1'b1, OFF_CFG, (k == 4) ? 32'h3F : 32'h30);
         apb(1'b1, OFF_STAT, 32'h7F);
         apb(1'b1, OFF_CTRL, 32'h5);
         wt(40);
         apb(1'b1, OFF_CTRL, 32'h4);
         wt(60);
         rd(OFF_STAT, es[k]);
      end
      // negative logic: a tripped drive drops the line
      trip <= 1'b1;
      wt(3);
      chk({31'h0, irq}, 32'h1);
      rd(OFF_STAT, 32'h1);
      rd(OFF_IRQ, 32'h1);
      trip <= 1'b0;
      apb(1'b1, OFF_MASK, 32'h0);
      wt(1);
      chk({31'h0, irq}, 32'h0);
      rd(OFF_IRQ, 32'h0);
      apb(1'b1, OFF_STAT, 32'h1);
      rd(OFF_STAT, 32'h0);
      completeRun();
   end
endmodule : tb_drive_status_interlock_monitor
`default_nettype wire
